/* File: hdl/adc_sample_timer.sv */
// Sequencer timebase, converter sample point, live counters and demodulator gating
//
// Added by the designer: the Avalon-MM slave port.
`timescale 1ns/1ps

module adc_sample_timer #(
    parameter int DIV_WIDTH = 16
) (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire logic [7:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    output adc_timing_pkg::afe_drive_t o_drive,
    output logic o_running
);
    localparam int TICK_W = DIV_WIDTH + 5;

    logic pending;
    logic [31:0] timebase;
    logic [15:0] period;
    adc_timing_pkg::adc_timing_t sample_cfg;
    adc_timing_pkg::window_t win_pos;
    adc_timing_pkg::window_t win_neg;
    logic [31:0] modes;
    logic [31:0] demod_ctrl;
    logic running;
    logic [TICK_W-1:0] tick_clk;
    adc_timing_pkg::progress_t prog;
    logic [7:0] tally;
    logic [19:0] sample_now;
    logic fired;
    logic [31:0] next_readdata;

    logic wr_ok;
    logic [TICK_W-1:0] clocks_per_tick;
    logic tick_end;
    logic cycle_end;
    logic seq_done;
    logic converting;
    logic frac_reached;
    logic adc_pulse;
    logic start_req;
    logic stop_req;
    logic [7:0] subs_ratio;
    logic [3:0] mode_a;
    logic [3:0] mode_b;

    // Merge a bus write into an old word by byte lane
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    // One wait state per access: the readdata flop is loaded in the first cycle
    assign o_avs_waitrequest = (i_avs_read || i_avs_write) && !pending;
    assign wr_ok = i_avs_write && pending;
    assign start_req = wr_ok && i_avs_address == adc_timing_pkg::OFS_RUN
                       && i_avs_byteenable[0] && i_avs_writedata[adc_timing_pkg::RUN_BIT];
    assign stop_req = wr_ok && i_avs_address == adc_timing_pkg::OFS_RUN
                      && i_avs_byteenable[0] && !i_avs_writedata[adc_timing_pkg::RUN_BIT];

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pending <= 1'b0;
        end else begin
            pending <= (i_avs_read || i_avs_write) && !pending;
        end
    end

    // Read mux; unmapped offsets read zero
    always_comb begin
        next_readdata = 32'h0000_0000;
        case (i_avs_address)
            adc_timing_pkg::OFS_TIMEBASE: next_readdata = timebase;
            adc_timing_pkg::OFS_RUN: next_readdata = {31'h0000_0000, running};
            adc_timing_pkg::OFS_PERIOD: next_readdata = {16'h0000, period};
            adc_timing_pkg::OFS_DEMOD_POS: next_readdata = win_pos;
            adc_timing_pkg::OFS_DEMOD_NEG: next_readdata = win_neg;
            adc_timing_pkg::OFS_SAMPLE: next_readdata = sample_cfg;
            adc_timing_pkg::OFS_MODES: next_readdata = modes;
            adc_timing_pkg::OFS_DEMOD_CTRL: next_readdata = demod_ctrl;
            adc_timing_pkg::OFS_PROGRESS: next_readdata = prog;
            adc_timing_pkg::OFS_TALLY: next_readdata = {24'h00_0000, tally};
            default: next_readdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_avs_readdata <= 32'h0000_0000;
        end else if (i_avs_read && !pending) begin
            o_avs_readdata <= next_readdata;
        end
    end

    // Configuration registers; unmapped writes are dropped
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            timebase <= adc_timing_pkg::TIMEBASE_RESET;
            period <= adc_timing_pkg::PERIOD_RESET;
            sample_cfg <= adc_timing_pkg::SAMPLE_RESET;
            win_pos <= adc_timing_pkg::WINDOW_RESET;
            win_neg <= adc_timing_pkg::WINDOW_RESET;
            modes <= 32'h0000_0000;
            demod_ctrl <= 32'h0000_0000;
        end else if (wr_ok) begin
            case (i_avs_address)
                adc_timing_pkg::OFS_TIMEBASE:
                    timebase <= merge(timebase, i_avs_writedata, i_avs_byteenable) & 32'h00FF_FFFF;
                adc_timing_pkg::OFS_PERIOD:
                    period <= 16'(merge({16'h0000, period}, i_avs_writedata, i_avs_byteenable));
                adc_timing_pkg::OFS_DEMOD_POS:
                    win_pos <= merge(win_pos, i_avs_writedata, i_avs_byteenable);
                adc_timing_pkg::OFS_DEMOD_NEG:
                    win_neg <= merge(win_neg, i_avs_writedata, i_avs_byteenable);
                adc_timing_pkg::OFS_SAMPLE:
                    sample_cfg <= merge(sample_cfg, i_avs_writedata, i_avs_byteenable);
                adc_timing_pkg::OFS_MODES:
                    modes <= merge(modes, i_avs_writedata, i_avs_byteenable) & 32'h0000_00FF;
                adc_timing_pkg::OFS_DEMOD_CTRL:
                    demod_ctrl <= merge(demod_ctrl, i_avs_writedata, i_avs_byteenable)
                                  & 32'h0000_FF01;
                default: ;
            endcase
        end
    end

    // Tick length in clocks follows the divider
    assign clocks_per_tick = TICK_W'((timebase[8 +: DIV_WIDTH] + 1)
                             * adc_timing_pkg::BASE_CLOCKS);
    assign tick_end = running && tick_clk >= clocks_per_tick - 1'b1;
    assign cycle_end = tick_end && (prog.cycle + 16'h0001 >= period);
    assign seq_done = cycle_end && timebase[7:0] != 8'h00
                      && prog.measure + 8'h01 >= timebase[7:0];
    assign subs_ratio = demod_ctrl[adc_timing_pkg::SUBS_LSB +: 8];
    assign converting = prog.subs == subs_ratio;

    // Run flag: start from idle, stop on request or after the last measurement
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            running <= 1'b0;
        end else if (stop_req || seq_done) begin
            running <= 1'b0;
        end else if (start_req) begin
            running <= 1'b1;
        end
    end

    // Clock count inside the current tick
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tick_clk <= '0;
        end else if (!running || tick_end) begin
            tick_clk <= '0;
        end else begin
            tick_clk <= tick_clk + 1'b1;
        end
    end

    // Live counters, cleared at every start
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            prog <= '0;
        end else if (!running) begin
            prog <= '0;
        end else if (cycle_end) begin
            prog.cycle <= 16'h0000;
            prog.subs <= converting ? 8'h00 : prog.subs + 8'h01;
            prog.measure <= prog.measure + 8'h01;
        end else if (tick_end) begin
            prog.cycle <= prog.cycle + 16'h0001;
        end
    end

    // Fraction point: position in tick scaled by 16 against fract times tick length.
    // At a 100 ns clock and a zero divider a sixteenth is finer than one clock, so the point rounds up.
    assign frac_reached = {tick_clk, 4'h0} >= {4'h0, clocks_per_tick} * sample_now[3:0];
    assign adc_pulse = running && converting && !fired && frac_reached
                       && prog.cycle == sample_now[19:4];

    // One conversion per cycle at most
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            fired <= 1'b0;
        end else if (!running || cycle_end) begin
            fired <= 1'b0;
        end else if (adc_pulse) begin
            fired <= 1'b1;
        end
    end

    // Working sample time: tracks the programmed value only while stopped
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sample_now <= 20'h0_0000;
        end else if (!running) begin
            sample_now <= {sample_cfg.whole, sample_cfg.fract};
        end else if (adc_pulse) begin
            sample_now <= sample_now + {4'h0, sample_cfg.inc, sample_cfg.inc_fract};
        end
    end

    // Conversion tally wraps at eight bits
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            tally <= adc_timing_pkg::TALLY_RESET;
        end else if (adc_pulse) begin
            tally <= tally + 8'h01;
        end
    end

    // Emitter selection per measurement; unknown mode codes keep an emitter dark
    assign mode_a = modes[3:0];
    assign mode_b = modes[adc_timing_pkg::SECOND_MODE_LSB +: 4];

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_drive <= '0;
        end else begin
            o_drive.adc_start <= adc_pulse;
            o_drive.emitter[0] <= running && (mode_a == adc_timing_pkg::EMIT_EVERY
                || (mode_a == adc_timing_pkg::EMIT_EVEN && !prog.measure[0])
                || (mode_a == adc_timing_pkg::EMIT_ODD && prog.measure[0]));
            o_drive.emitter[1] <= running && (mode_b == adc_timing_pkg::EMIT_EVERY
                || (mode_b == adc_timing_pkg::EMIT_EVEN && !prog.measure[0])
                || (mode_b == adc_timing_pkg::EMIT_ODD && prog.measure[0]));
            // Demodulator timing comes from the cycle count, so it idles when stopped
            if (!running || !demod_ctrl[adc_timing_pkg::DEMOD_EN_BIT]) begin
                o_drive.factor <= adc_timing_pkg::FACTOR_ZERO;
            end else if (prog.cycle >= win_pos.start && prog.cycle < win_pos.stop) begin
                o_drive.factor <= adc_timing_pkg::FACTOR_PLUS;
            end else if (prog.cycle >= win_neg.start && prog.cycle < win_neg.stop) begin
                o_drive.factor <= adc_timing_pkg::FACTOR_MINUS;
            end else begin
                o_drive.factor <= adc_timing_pkg::FACTOR_ZERO;
            end
        end
    end

    assign o_running = running;

    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_rst_n);

    property p_adc_point;
        adc_pulse |-> running && converting && prog.cycle == sample_now[19:4]
            ##1 o_drive.adc_start;
    endproperty
    a_adc_point: assert property (p_adc_point) else $error("sample off whole tick");

    property p_frac_first;
        adc_pulse && tick_clk != '0 |-> !({tick_clk - 1'b1, 4'h0}
            >= {4'h0, clocks_per_tick} * sample_now[3:0]);
    endproperty
    a_frac_first: assert property (p_frac_first) else $error("sample late in tick");

    property p_increment;
        adc_pulse && !seq_done && !stop_req |=> sample_now == $past(sample_now)
            + {4'h0, $past(sample_cfg.inc), $past(sample_cfg.inc_fract)};
    endproperty
    a_increment: assert property (p_increment) else $error("increment not added");

    property p_frozen;
        running && $past(running) && !$past(adc_pulse) |-> $stable(sample_now);
    endproperty
    a_frozen: assert property (p_frozen) else $error("sample time moved");

    property p_tally;
        adc_pulse |=> tally == $past(tally) + 8'h01;
    endproperty
    a_tally: assert property (p_tally) else $error("tally missed");

    property p_tick_len;
        tick_end |-> tick_clk == clocks_per_tick - 1'b1;
    endproperty
    a_tick_len: assert property (p_tick_len) else $error("tick length wrong");

    property p_stop;
        running && stop_req |=> !running ##1 !o_running;
    endproperty
    a_stop: assert property (p_stop) else $error("stop ignored");

    property p_start_clear;
        $rose(running) |-> prog == '0 && tally == $past(tally);
    endproperty
    a_start_clear: assert property (p_start_clear) else $error("counters not cleared");

    property p_demod_idle;
        !running |=> o_drive.factor == adc_timing_pkg::FACTOR_ZERO;
    endproperty
    a_demod_idle: assert property (p_demod_idle) else $error("demod active idle");

    property p_both;
        running && mode_a == adc_timing_pkg::EMIT_EVERY
            && mode_b == adc_timing_pkg::EMIT_EVERY ##1 running |-> o_drive.emitter == 2'b11;
    endproperty
    a_both: assert property (p_both) else $error("emitters not both on");

    c_conversion: cover property (adc_pulse && sample_now[3:0] != 4'h0);
    c_carry: cover property (adc_pulse ##[1:1000] adc_pulse && sample_now[3:0] == 4'h0);
    c_done: cover property (seq_done);
    c_minus: cover property (o_drive.factor == adc_timing_pkg::FACTOR_MINUS);
endmodule : adc_sample_timer

/* File: inc/adc_timing_pkg.sv */
// Shared constants, register layout and carrier types for the sample timing block
package adc_timing_pkg;
    // Clock and timebase
    localparam int CLOCK_PERIOD_NS = 100;
    localparam int BASE_TICK_NS = 1000;
    localparam int BASE_CLOCKS = BASE_TICK_NS / CLOCK_PERIOD_NS;
    localparam int FRACTION_STEPS = 16;
    localparam int FRACTION_SHIFT = 4;
    // Register byte offsets
    localparam logic [7:0] OFS_TIMEBASE = 8'h24;
    localparam logic [7:0] OFS_RUN = 8'h28;
    localparam logic [7:0] OFS_PERIOD = 8'h2C;
    localparam logic [7:0] OFS_DEMOD_POS = 8'h38;
    localparam logic [7:0] OFS_DEMOD_NEG = 8'h3C;
    localparam logic [7:0] OFS_SAMPLE = 8'h44;
    localparam logic [7:0] OFS_MODES = 8'h48;
    localparam logic [7:0] OFS_DEMOD_CTRL = 8'h4C;
    localparam logic [7:0] OFS_PROGRESS = 8'h80;
    localparam logic [7:0] OFS_TALLY = 8'h84;
    // Field positions not carried by a struct
    localparam int RUN_BIT = 0;
    localparam int DEMOD_EN_BIT = 0;
    localparam int SUBS_LSB = 8;
    localparam int SECOND_MODE_LSB = 4;
    // Reset values
    localparam logic [31:0] SAMPLE_RESET = 32'h0000_0000;
    localparam logic [31:0] TIMEBASE_RESET = 32'h0000_0000;
    localparam logic [15:0] PERIOD_RESET = 16'h0000;
    localparam logic [31:0] WINDOW_RESET = 32'h0000_0000;
    localparam logic [7:0] TALLY_RESET = 8'h00;
    // Emitter mode codes
    localparam logic [3:0] EMIT_EVERY = 4'h2;
    localparam logic [3:0] EMIT_EVEN = 4'h3;
    localparam logic [3:0] EMIT_ODD = 4'h4;

    typedef struct packed {
        logic [3:0] inc_fract;
        logic [3:0] fract;
        logic [7:0] inc;
        logic [15:0] whole;
    } adc_timing_t;

    typedef struct packed {
        logic [7:0] subs;
        logic [7:0] measure;
        logic [15:0] cycle;
    } progress_t;

    typedef struct packed {
        logic [15:0] start;
        logic [15:0] stop;
    } window_t;

    typedef enum logic [1:0] {
        FACTOR_ZERO,
        FACTOR_PLUS,
        FACTOR_MINUS
    } demod_factor_t;

    typedef struct packed {
        logic adc_start;
        logic [1:0] emitter;
        demod_factor_t factor;
    } afe_drive_t;
endpackage : adc_timing_pkg

/* File: dv/afe_model.sv */
// Behavioural model of the analog front end that logs each converter start
`timescale 1ns/1ps
module afe_model (
    input wire logic i_clock,
    input wire logic i_rst_n,
    input wire adc_timing_pkg::afe_drive_t i_drive,
    input wire logic [31:0] i_stamp,
    output logic [7:0] o_conversions,
    output logic [31:0] o_last_stamp,
    output logic [1:0] o_last_emitter
);
    // A start pulse begins one conversion; the bench stamp and the emitters are taken with it
    // The front end has no return path, so the model can only listen, never stall
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_conversions <= 8'h00;
            o_last_stamp <= 32'h0000_0000;
            o_last_emitter <= 2'h0;
        end else if (i_drive.adc_start === 1'b1) begin
            o_conversions <= o_conversions + 8'h01;
            o_last_stamp <= i_stamp;
            o_last_emitter <= i_drive.emitter;
        end
    end
endmodule : afe_model

/* File: dv/test_sequencer_adc_sample_timing.sv */
// Self-checking bench for the converter sample timing block
`timescale 1ns/1ps
module test_sequencer_adc_sample_timing;
    logic i_clock;
    logic i_rst_n;
    logic [7:0] addr;
    logic rd;
    logic wr;
    logic [31:0] wdata;
    logic [3:0] be;
    logic [31:0] rdata;
    logic waitreq;
    adc_timing_pkg::afe_drive_t drive;
    logic running;
    logic [31:0] run_clocks = 32'h0000_0000;
    logic [7:0] conv;
    logic [31:0] stamp;
    logic [1:0] emit;
    int err_count = 0;
    int total_checks = 0;

    adc_sample_timer u_adc_sample_timer (.i_clock(i_clock), .i_rst_n(i_rst_n),
        .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata),
        .i_avs_byteenable(be), .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq),
        .o_drive(drive), .o_running(running));

    afe_model u_afe_model (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_drive(drive),
        .i_stamp(run_clocks), .o_conversions(conv), .o_last_stamp(stamp),
        .o_last_emitter(emit));

    // Clocks spent running, so sample points are measured from the start
    always @(posedge i_clock) begin
        run_clocks <= (running === 1'b1) ? run_clocks + 32'h1 : 32'h0;
    end

    initial begin
        i_clock = 1'b0;
        forever #50 i_clock = ~i_clock;
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : final_report

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic timeout(input string what);
        err_count++;
        $display("FAIL timeout %s", what);
        final_report();
    endtask : timeout

    // One bus access; waitrequest and readdata are taken at the rising edge
    task automatic bus(input logic dir, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] lanes, output logic [31:0] q);
        logic w;
        int n;
        w = 1'b1;
        n = 0;
        @(posedge i_clock);
        addr <= a;
        wdata <= d;
        be <= lanes;
        wr <= dir;
        rd <= !dir;
        while (w !== 1'b0 && n < 20) begin
            @(posedge i_clock);
            w = waitreq;
            q = rdata;
            n++;
        end
        wr <= 1'b0;
        rd <= 1'b0;
        if (w !== 1'b0) timeout("bus");
    endtask : bus

    task automatic wr32(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, 4'hF, q);
    endtask : wr32

    task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0000_0000, 4'h0, q);
        check(name, q, e);
    endtask : rd_chk

    function automatic logic fires(input logic [3:0] m, input int k);
        return m == 4'h2 || (m == 4'h3 && k % 2 == 0) || (m == 4'h4 && k % 2 == 1);
    endfunction : fires

    task automatic test_regs();
        logic [31:0] q;
        rd_chk("sample reset", adc_timing_pkg::OFS_SAMPLE, 32'h0000_0000);
        rd_chk("tally reset", adc_timing_pkg::OFS_TALLY, 32'h0000_0000);
        wr32(adc_timing_pkg::OFS_PROGRESS, 32'hFFFF_FFFF);
        rd_chk("progress", adc_timing_pkg::OFS_PROGRESS, 32'h0000_0000);
        wr32(8'hF0, 32'hFFFF_FFFF);
        rd_chk("unmapped", 8'hF0, 32'h0000_0000);
        wr32(adc_timing_pkg::OFS_SAMPLE, 32'h1234_5678);
        bus(1'b1, adc_timing_pkg::OFS_SAMPLE, 32'hFFFF_FFFF, 4'h1, q);
        rd_chk("sample lanes", adc_timing_pkg::OFS_SAMPLE, 32'h1234_56FF);
        $display("test_regs done");
    endtask : test_regs

    // Program one sequence and judge every conversion's moment and emitters
    task automatic run_seq(input logic [15:0] div, input logic [15:0] per,
        input logic [7:0] cnt, input logic [15:0] w, input logic [3:0] f,
        input logic [7:0] inc, input logic [3:0] fi, input logic [3:0] m1,
        input logic [3:0] m2);
        int t;
        int s;
        int e;
        int n;
        logic [7:0] base;
        t = (int'(div) + 1) * adc_timing_pkg::BASE_CLOCKS;
        s = int'(w) * 16 + int'(f);
        wr32(adc_timing_pkg::OFS_TIMEBASE, {8'h00, div, cnt});
        wr32(adc_timing_pkg::OFS_PERIOD, {16'h0000, per});
        wr32(adc_timing_pkg::OFS_MODES, {24'h000000, m2, m1});
        wr32(adc_timing_pkg::OFS_SAMPLE, {fi, f, inc, w});
        base = conv;
        wr32(adc_timing_pkg::OFS_RUN, 32'h0000_0001);
        rd_chk("progress at start", adc_timing_pkg::OFS_PROGRESS, 32'h0000_0000);
        rd_chk("run bit", adc_timing_pkg::OFS_RUN, 32'h0000_0001);
        // A new sample time written while running must not move the sample point
        wr32(adc_timing_pkg::OFS_SAMPLE, {fi, f, inc, w + 16'h0001});
        for (int k = 0; k < int'(cnt); k++) begin
            n = 0;
            while (conv === 8'(int'(base) + k) && n < 5000) begin
                @(posedge i_clock);
                n++;
            end
            if (n == 5000) timeout("conversion");
            e = k * int'(per) * t + (s >> 4) * t + ((s & 15) * t + 15) / 16 + 1;
            check("sample stamp", stamp, 32'(e));
            check("emitters", {30'h0, emit}, {30'h0, fires(m2, k), fires(m1, k)});
            s = s + int'(inc) * 16 + int'(fi);
        end
        n = 0;
        while (running !== 1'b0 && n < 5000) begin
            @(posedge i_clock);
            n++;
        end
        if (n == 5000) timeout("self stop");
    endtask : run_seq

    task automatic test_timing();
        run_seq(16'h0000, 16'h0008, 8'h03, 16'h0001, 4'hC, 8'h01, 4'h8, 4'h2, 4'h0);
        rd_chk("tally", adc_timing_pkg::OFS_TALLY, 32'h0000_0003);
        run_seq(16'h0001, 16'h0004, 8'h02, 16'h0001, 4'h8, 8'h00, 4'h4, 4'h2, 4'h0);
        $display("test_timing done");
    endtask : test_timing

    task automatic test_modes();
        logic [7:0] pairs [4];
        pairs = '{8'h20, 8'h02, 8'h34, 8'h22};
        for (int p = 0; p < 4; p++) begin
            run_seq(16'h0000, 16'h0002, 8'h02, 16'h0001, 4'h0, 8'h00, 4'h0,
                pairs[p][7:4], pairs[p][3:0]);
        end
        // Emitter lit from cycle start, sample taken ten ticks later
        run_seq(16'h0000, 16'h000C, 8'h02, 16'h000A, 4'h0, 8'h00, 4'h0, 4'h3, 4'h4);
        $display("test_modes done");
    endtask : test_modes

    // Positive window in tick 0, negative in tick 1, nothing in tick 2
    task automatic test_demod();
        int n;
        logic [1:0] f;
        wr32(adc_timing_pkg::OFS_DEMOD_POS, 32'h0000_0001);
        wr32(adc_timing_pkg::OFS_DEMOD_NEG, 32'h0001_0002);
        wr32(adc_timing_pkg::OFS_DEMOD_CTRL, 32'h0000_0101);
        wr32(adc_timing_pkg::OFS_TIMEBASE, 32'h0000_0000);
        wr32(adc_timing_pkg::OFS_PERIOD, 32'h0000_0003);
        check("factor idle", 32'(drive.factor), 32'(adc_timing_pkg::FACTOR_ZERO));
        wr32(adc_timing_pkg::OFS_RUN, 32'h0000_0001);
        for (int k = 0; k < 4; k++) begin
            n = 0;
            while (run_clocks !== 32'(5 + 10 * k) && n < 200) begin
                @(negedge i_clock);
                n++;
            end
            if (n == 200) timeout("demod tick");
            f = (k % 3 == 0) ? 2'(adc_timing_pkg::FACTOR_PLUS) :
                (k % 3 == 1) ? 2'(adc_timing_pkg::FACTOR_MINUS) : 2'(adc_timing_pkg::FACTOR_ZERO);
            check("factor", 32'(drive.factor), {30'h0, f});
        end
        // Second measurement, first tick, subsample count one
        rd_chk("progress live", adc_timing_pkg::OFS_PROGRESS, 32'h0101_0000);
        wr32(adc_timing_pkg::OFS_RUN, 32'h0000_0000);
        repeat (2) @(posedge i_clock);
        @(negedge i_clock);
        check("stopped", {31'h0, running}, 32'h0000_0000);
        check("factor stopped", 32'(drive.factor), 32'(adc_timing_pkg::FACTOR_ZERO));
        rd_chk("run bit clear", adc_timing_pkg::OFS_RUN, 32'h0000_0000);
        $display("test_demod done");
    endtask : test_demod

    initial begin
        i_rst_n = 1'b0;
        rd = 1'b0;
        wr = 1'b0;
        addr = 8'h00;
        wdata = 32'h0000_0000;
        be = 4'h0;
        repeat (4) @(posedge i_clock);
        i_rst_n <= 1'b1;
        test_regs();
        test_timing();
        test_modes();
        test_demod();
        final_report();
    end
endmodule : test_sequencer_adc_sample_timing
